//--- ecl_consts.svh
`ifndef ECL_CONSTS_SVH
`define ECL_CONSTS_SVH
// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define ECL_OFF_STATUS 12'h000
`define ECL_OFF_MASK 12'h004
`define ECL_OFF_STATE 12'h008
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ECL_OE_RST 2'h0
`define ECL_ST_RST 2'h3
`define ECL_RX_RST 1'h0
`define ECL_FAULT_N_RST 1'h0
`define ECL_EVT_RST 5'h00
// reset pin bit idles high so a release shows no false device reset
`define ECL_SYNC_RST 6'h20
`define ECL_WORD_ZERO 32'h00000000
// ----------------------------------------------------------------
// event bit positions (status and mask share them)
// ----------------------------------------------------------------
`define ECL_EVT_OE 0
`define ECL_EVT_ST 1
`define ECL_EVT_RX 2
`define ECL_EVT_FAULT 3
`define ECL_EVT_DEVRST 4
// ----------------------------------------------------------------
// state register fields
// ----------------------------------------------------------------
`define ECL_ST_DRV_LSB 0
`define ECL_ST_BIST_LSB 2
`define ECL_ST_RXPWR 4
`define ECL_ST_FAULT 5
`define ECL_ST_DEVRST 6
// ----------------------------------------------------------------
// synchroniser bit positions
// ----------------------------------------------------------------
`define ECL_SY_EN_LSB 0
`define ECL_SY_OE 2
`define ECL_SY_ST 3
`define ECL_SY_RX 4
`define ECL_SY_RSTN 5
`endif

//--- ecl_pkg.sv
`default_nettype none
package ecl_pkg;
  typedef logic [1:0] ecl_en_t;
  typedef logic [4:0] ecl_evt_t;
  typedef logic [5:0] ecl_sync_t;
  typedef logic [11:0] ecl_addr_t;
  typedef logic [31:0] ecl_word_t;
endpackage
`default_nettype wire

//--- ecl_strobe_latch.sv
`timescale 1ns/100ps
`default_nettype none
module ecl_strobe_latch
  import ecl_pkg::*;
#(
  parameter int W = 2,
  parameter logic [W-1:0] RESET_VAL = '0,
  parameter bit CLEAR_CLOSED_ONLY = 1'b0
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic strobe,
  input wire logic [W-1:0] data,
  input wire logic clear,
  output logic [W-1:0] value,
  output logic loaded
);
  logic [W-1:0] value_reg;
  logic [W-1:0] value_next;
  logic strobePrev_reg;
  logic strobePrev_next;

  // ----------------------------------------------------------------
  // latch emulation
  // ----------------------------------------------------------------
  // open latch follows data each cycle; on close the last sample stays
  always_comb begin
    value_next = value_reg;
    strobePrev_next = strobe;
    if (clear && (!CLEAR_CLOSED_ONLY || !strobe)) begin
      value_next = RESET_VAL;
    end else if (strobe) begin
      value_next = data;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      value_reg <= RESET_VAL;
      strobePrev_reg <= 1'b0;
    end else if (clkEn) begin
      value_reg <= value_next;
      strobePrev_reg <= strobePrev_next;
    end
  end

  assign value = value_reg;
  assign loaded = strobePrev_reg && !strobe;
endmodule // ecl_strobe_latch
`default_nettype wire

//--- ecl_enable_latch_control.sv
// Overview of operation
// - open output-enable strobe passes shared enables to both driver enables
// - driver enable one switches driver on, zero powers it down
// - output-enable strobe falling holds the last shared enable values
// - device reset clears output-enable latch, both drivers off
// - open self-test strobe passes enables; zero tests, one is normal
// - self-test strobe falling holds the last shared enable values
// - device reset with self-test latch closed disables self-test both ways
// - open receive-power strobe passes enable bit zero to receive power
// - receive-power strobe falling holds enable bit zero
// - device reset with receive-power latch closed disables receiver
// - one shared enable bus feeds all three latches; host sets it first
// - active-low link fault is OR of four receive health conditions
// - active-low device reset sampled on clock edge clears the output-enable latch and any closed latch
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "ecl_consts.svh"
module ecl_enable_latch_control
  import ecl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic outputEnableLatchStrobe,
  input wire logic selftestLatchStrobe,
  input wire logic receivePowerLatchStrobe,
  input wire logic [1:0] sharedEnableInputs,
  input wire logic deviceReset_n,
  input wire logic rxFreqFault,
  input wire logic rxAmplitudeLow,
  input wire logic rxDensityLow,
  output logic [1:0] serialDriverPairEn,
  output logic txSelftestNormal,
  output logic rxSelftestNormal,
  output logic rxPowerEnable,
  output logic linkFault_n,
  output logic irq,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  // every host latch pin is asynchronous, so all pass two flops together; receive fault inputs do not
  ecl_sync_t syncA_reg;
  ecl_sync_t syncB_reg;
  ecl_sync_t syncA_next;
  ecl_sync_t syncB_next;

  always_comb begin
    syncA_next = {deviceReset_n, receivePowerLatchStrobe,
                  selftestLatchStrobe, outputEnableLatchStrobe,
                  sharedEnableInputs};
    syncB_next = syncA_reg;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      syncA_reg <= `ECL_SYNC_RST;
      syncB_reg <= `ECL_SYNC_RST;
    end else if (clkEn) begin
      syncA_reg <= syncA_next;
      syncB_reg <= syncB_next;
    end
  end

  ecl_en_t enS;
  logic oeS;
  logic stS;
  logic rxS;
  logic devRst;
  assign enS = syncB_reg[`ECL_SY_EN_LSB +: 2];
  assign oeS = syncB_reg[`ECL_SY_OE];
  assign stS = syncB_reg[`ECL_SY_ST];
  assign rxS = syncB_reg[`ECL_SY_RX];
  assign devRst = !syncB_reg[`ECL_SY_RSTN];

  // ----------------------------------------------------------------
  // enable latches
  // ----------------------------------------------------------------
  ecl_en_t oeVal;
  ecl_en_t stVal;
  logic rxVal;
  logic oeLoaded;
  logic stLoaded;
  logic rxLoaded;

  ecl_strobe_latch #(
    .W(2),
    .RESET_VAL(`ECL_OE_RST),
    .CLEAR_CLOSED_ONLY(1'b0)
  ) u_oe_latch (
    .clk_sys(clk_sys),
    .reset(reset),
    .clkEn(clkEn),
    .strobe(oeS),
    .data(enS),
    .clear(devRst),
    .value(oeVal),
    .loaded(oeLoaded)
  );

  ecl_strobe_latch #(
    .W(2),
    .RESET_VAL(`ECL_ST_RST),
    .CLEAR_CLOSED_ONLY(1'b1)
  ) u_st_latch (
    .clk_sys(clk_sys),
    .reset(reset),
    .clkEn(clkEn),
    .strobe(stS),
    .data(enS),
    .clear(devRst),
    .value(stVal),
    .loaded(stLoaded)
  );

  ecl_strobe_latch #(
    .W(1),
    .RESET_VAL(`ECL_RX_RST),
    .CLEAR_CLOSED_ONLY(1'b1)
  ) u_rx_latch (
    .clk_sys(clk_sys),
    .reset(reset),
    .clkEn(clkEn),
    .strobe(rxS),
    .data(enS[0]),
    .clear(devRst),
    .value(rxVal),
    .loaded(rxLoaded)
  );

  assign serialDriverPairEn = oeVal;
  assign rxSelftestNormal = stVal[0];
  assign txSelftestNormal = stVal[1];
  assign rxPowerEnable = rxVal;

  // ----------------------------------------------------------------
  // link fault
  // ----------------------------------------------------------------
  // registered so the pin never glitches on condition skew
  logic faultAny;
  logic linkFault_n_reg;
  logic linkFault_n_next;

  always_comb begin
    faultAny = rxFreqFault || rxAmplitudeLow || rxDensityLow || !rxVal;
    linkFault_n_next = !faultAny;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      linkFault_n_reg <= `ECL_FAULT_N_RST;
    end else if (clkEn) begin
      linkFault_n_reg <= linkFault_n_next;
    end
  end
  assign linkFault_n = linkFault_n_reg;

  // ----------------------------------------------------------------
  // apb slave and interrupt registers
  // ----------------------------------------------------------------
  function automatic logic regHit(input ecl_addr_t a, input ecl_addr_t off);
    regHit = (a == off);
  endfunction

  ecl_evt_t status_reg;
  ecl_evt_t status_next;
  ecl_evt_t mask_reg;
  ecl_evt_t mask_next;
  ecl_word_t prdata_reg;
  ecl_word_t prdata_next;
  logic err_reg;
  logic err_next;
  logic devRstPrev_reg;
  logic devRstPrev_next;
  ecl_evt_t events;
  logic setup;
  logic access;
  logic mapped;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign mapped = regHit(paddr, `ECL_OFF_STATUS) ||
                  regHit(paddr, `ECL_OFF_MASK) ||
                  regHit(paddr, `ECL_OFF_STATE);

  always_comb begin
    events = `ECL_EVT_RST;
    events[`ECL_EVT_OE] = oeLoaded;
    events[`ECL_EVT_ST] = stLoaded;
    events[`ECL_EVT_RX] = rxLoaded;
    events[`ECL_EVT_FAULT] = linkFault_n_reg && !linkFault_n_next;
    events[`ECL_EVT_DEVRST] = devRst && !devRstPrev_reg;
    devRstPrev_next = devRst;
    prdata_next = prdata_reg;
    err_next = err_reg;
    mask_next = mask_reg;
    status_next = status_reg;
    // read data is sampled in setup; only those bits are cleared later
    if (setup) begin
      err_next = !mapped;
      prdata_next = `ECL_WORD_ZERO;
      if (regHit(paddr, `ECL_OFF_STATUS)) begin
        prdata_next[4:0] = status_reg;
      end else if (regHit(paddr, `ECL_OFF_MASK)) begin
        prdata_next[4:0] = mask_reg;
      end else if (regHit(paddr, `ECL_OFF_STATE)) begin
        prdata_next[`ECL_ST_DRV_LSB +: 2] = oeVal;
        prdata_next[`ECL_ST_BIST_LSB +: 2] = stVal;
        prdata_next[`ECL_ST_RXPWR] = rxVal;
        prdata_next[`ECL_ST_FAULT] = !linkFault_n_reg;
        prdata_next[`ECL_ST_DEVRST] = devRst;
      end
    end
    if (access && pwrite && regHit(paddr, `ECL_OFF_MASK)) begin
      mask_next = pwdata[4:0];
    end
    if (access && !pwrite && regHit(paddr, `ECL_OFF_STATUS)) begin
      status_next = status_reg & ~prdata_reg[4:0];
    end
    // a new event in the clearing cycle survives
    status_next = status_next | events;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      status_reg <= `ECL_EVT_RST;
      mask_reg <= `ECL_EVT_RST;
      prdata_reg <= `ECL_WORD_ZERO;
      err_reg <= 1'b0;
      devRstPrev_reg <= 1'b0;
    end else if (clkEn) begin
      status_reg <= status_next;
      mask_reg <= mask_next;
      prdata_reg <= prdata_next;
      err_reg <= err_next;
      devRstPrev_reg <= devRstPrev_next;
    end
  end

  // limitation: with clkEn low the bus stalls since pready needs it
  assign pready = access && clkEn;
  assign pslverr = pready && err_reg;
  assign prdata = prdata_reg;
  assign irq = |(status_reg & mask_reg);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_oe_follow: assert property (
    @(posedge clk_sys) disable iff (reset)
    (clkEn && oeS && !devRst) |=> serialDriverPairEn == $past(enS))
    else $error("driver enables not following open latch");

  a_oe_hold: assert property (
    @(posedge clk_sys) disable iff (reset)
    (clkEn && !oeS && !devRst) |=> $stable(serialDriverPairEn))
    else $error("closed output latch changed");

  a_oe_reset: assert property (
    @(posedge clk_sys) disable iff (reset)
    (clkEn && devRst) |=> serialDriverPairEn == `ECL_OE_RST)
    else $error("device reset left a driver on");

  a_st_map: assert property (
    @(posedge clk_sys) disable iff (reset)
    (clkEn && stS) |=> {txSelftestNormal, rxSelftestNormal} == $past(enS))
    else $error("self-test enables not following open latch");

  a_st_hold: assert property (
    @(posedge clk_sys) disable iff (reset)
    (clkEn && !stS && !devRst) |=> $stable(stVal))
    else $error("closed self-test latch changed");

  a_st_reset: assert property (
    @(posedge clk_sys) disable iff (reset)
    (clkEn && devRst && !stS) |=> txSelftestNormal && rxSelftestNormal)
    else $error("device reset left self-test on");

  a_rx_follow: assert property (
    @(posedge clk_sys) disable iff (reset)
    (clkEn && rxS) |=> rxPowerEnable == $past(enS[0]))
    else $error("receive power not following bit zero");

  a_rx_hold: assert property (
    @(posedge clk_sys) disable iff (reset)
    (clkEn && !rxS && !devRst) |=> $stable(rxPowerEnable))
    else $error("closed receive power latch changed");

  a_rx_reset: assert property (
    @(posedge clk_sys) disable iff (reset)
    (clkEn && devRst && !rxS) |=> !rxPowerEnable)
    else $error("device reset left receiver powered");

  a_shared_bus: assert property (
    @(posedge clk_sys) disable iff (reset)
    (clkEn && oeS && stS && !devRst) |=> stVal == serialDriverPairEn)
    else $error("latches saw different bus values");

  a_fault_or: assert property (
    @(posedge clk_sys) disable iff (reset)
    clkEn |=> linkFault_n == !($past(rxFreqFault) || $past(rxAmplitudeLow)
      || $past(rxDensityLow) || !$past(rxPowerEnable)))
    else $error("link fault not the OR of its causes");

  a_devrst_pin: assert property (
    @(posedge clk_sys) disable iff (reset)
    (!deviceReset_n && clkEn)[*3] |=> serialDriverPairEn == `ECL_OE_RST)
    else $error("reset pin did not clear drivers in three cycles");

  a_irq_event: assert property (
    @(posedge clk_sys) disable iff (reset)
    (clkEn && |(events & mask_next)) |=> irq)
    else $error("masked-in event did not raise interrupt");
endmodule // ecl_enable_latch_control
`default_nettype wire

//--- ecl_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module ecl_host_model (
  input wire logic clk_sys,
  output logic oeStrobe,
  output logic stStrobe,
  output logic rxStrobe,
  output logic [1:0] enBus,
  output logic devRst_n
);
  logic [2:0] strobeVec;
  assign {rxStrobe, stStrobe, oeStrobe} = strobeVec;
  initial begin
    strobeVec = 3'h0;
    enBus = 2'h3;
    devRst_n = 1'b1;
  end
  // ----------------------------------------
  // host sequences
  // ----------------------------------------
  // bus before strobe
  task automatic open_latch(input logic [1:0] sel, input logic [1:0] val);
    enBus <= val;
    @(posedge clk_sys);
    strobeVec <= 3'h1 << sel;
    repeat (5) @(posedge clk_sys);
  endtask
  task automatic open_pair(input logic [1:0] val);
    enBus <= val;
    @(posedge clk_sys);
    strobeVec <= 3'h3;
    repeat (5) @(posedge clk_sys);
  endtask
  task automatic close_latch();
    strobeVec <= 3'h0;
    repeat (4) @(posedge clk_sys);
    // released bus floats to its pull-up level, so a held value is tested
    enBus <= 2'h3;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic pulse_reset();
    devRst_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    devRst_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
  endtask
endmodule // ecl_host_model
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "ecl_consts.svh"
module tb_top
  import ecl_pkg::*;
();
  logic clk_sys, reset, clkEn, psel, penable, pwrite;
  logic rxFreqFault, rxAmplitudeLow, rxDensityLow;
  logic [11:0] paddr;
  ecl_word_t pwdata, prdata, rdat;
  logic pready, pslverr, rerr, txN, rxN, rxPwr, linkFault_n, irq;
  wire logic oeS, stS, rxS, devRst_n;
  wire logic [1:0] enBus;
  logic [1:0] drvEn;
  int nErrors, comparisons, i;
  logic [8:0] r;
  // row: latch, bus value, then driver, self-test {tx,rx}, rx power
  logic [8:0] rows [6] = '{9'h02e, 9'h056, 9'h090, 9'h0b2, 9'h133, 9'h07b};

  ecl_host_model host (.clk_sys(clk_sys), .oeStrobe(oeS), .stStrobe(stS),
    .rxStrobe(rxS), .enBus(enBus), .devRst_n(devRst_n));
  ecl_enable_latch_control dut (.clk_sys(clk_sys), .reset(reset),
    .clkEn(clkEn), .outputEnableLatchStrobe(oeS),
    .selftestLatchStrobe(stS), .receivePowerLatchStrobe(rxS),
    .sharedEnableInputs(enBus), .deviceReset_n(devRst_n),
    .rxFreqFault(rxFreqFault), .rxAmplitudeLow(rxAmplitudeLow),
    .rxDensityLow(rxDensityLow), .serialDriverPairEn(drvEn),
    .txSelftestNormal(txN), .rxSelftestNormal(rxN),
    .rxPowerEnable(rxPwr), .linkFault_n(linkFault_n), .irq(irq),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      nErrors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    // no fixed wait: only the watchdog ends a stalled access
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic load(input logic [1:0] sel, input logic [1:0] val);
    host.open_latch(sel, val);
    host.close_latch();
  endtask
  task automatic finalReport();
    $display("errors %0d comparisons %0d", nErrors, comparisons);
    if (nErrors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------
  // clock and watchdog
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // the whole sequence needs well under 1500 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    nErrors++;
    finalReport();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    reset = 1'b1;
    clkEn = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    {rxDensityLow, rxAmplitudeLow, rxFreqFault} = 3'h0;
    nErrors = 0;
    comparisons = 0;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    apb(1'b0, `ECL_OFF_STATE, 32'h0);
    chk(rdat, 32'h0000002c);
    chk({31'h0, irq}, 32'h0);
    for (i = 0; i < 6; i++) begin
      r = rows[i];
      host.open_latch(r[8:7], r[6:5]);
      chk({27'h0, drvEn, txN, rxN, rxPwr}, {27'h0, r[4:0]});
      host.close_latch();
      chk({27'h0, drvEn, txN, rxN, rxPwr}, {27'h0, r[4:0]});
      apb(1'b0, `ECL_OFF_STATE, 32'h0);
      chk(rdat, {26'h0, ~r[0], r[0], r[2:1], r[4:3]});
    end
    for (i = 0; i < 3; i++) begin
      {rxDensityLow, rxAmplitudeLow, rxFreqFault} <= 3'h1 << i;
      repeat (3) @(posedge clk_sys);
      chk({31'h0, linkFault_n}, 32'h0);
      {rxDensityLow, rxAmplitudeLow, rxFreqFault} <= 3'h0;
      repeat (3) @(posedge clk_sys);
      chk({31'h0, linkFault_n}, 32'h1);
    end
    // interrupt: all load and fault events seen, mask in, raise, clear
    apb(1'b0, `ECL_OFF_STATUS, 32'h0);
    chk(rdat, 32'h0000000f);
    apb(1'b1, `ECL_OFF_MASK, 32'h1);
    apb(1'b0, `ECL_OFF_MASK, 32'h0);
    chk(rdat, 32'h1);
    chk({31'h0, rerr}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    load(2'h0, 2'h2);
    repeat (3) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, `ECL_OFF_STATUS, 32'h0);
    chk(rdat, 32'h1);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `ECL_OFF_MASK, 32'h0);
    load(2'h0, 2'h3);
    repeat (3) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    // unmapped address and read-only state
    apb(1'b0, 12'h00c, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
    apb(1'b1, `ECL_OFF_STATE, 32'h0);
    apb(1'b0, `ECL_OFF_STATE, 32'h0);
    chk(rdat, 32'h00000017);
    // two latches open at once take one bus value
    host.open_pair(2'h2);
    host.close_latch();
    chk({27'h0, drvEn, txN, rxN, rxPwr}, 32'h00000015);
    // device reset pin with every latch closed
    host.pulse_reset();
    apb(1'b0, `ECL_OFF_STATE, 32'h0);
    chk(rdat, 32'h0000002c);
    chk({31'h0, linkFault_n}, 32'h0);
    // self-test latch still open: device reset leaves it following
    host.open_latch(2'h1, 2'h0);
    host.pulse_reset();
    chk({30'h0, txN, rxN}, 32'h0);
    host.close_latch();
    chk({30'h0, txN, rxN}, 32'h0);
    // async reset in mid-run returns every latch to its reset value
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk({27'h0, drvEn, txN, rxN, rxPwr}, 32'h00000006);
    chk({31'h0, linkFault_n}, 32'h0);
    finalReport();
  end
endmodule // tb_top
`default_nettype wire
